// >>> verilog/dual_pot_params.svh
// Constants for the dual potentiometer serial command unit.
// Assumes inclusion by the package and the design module only.
`ifndef DUAL_POT_PARAMS_SVH
`define DUAL_POT_PARAMS_SVH

`define POT_WIDTH 8
`define POT_MID_SCALE 8'h80
`define CMD_SEL_A_BIT 0
`define CMD_SEL_B_BIT 1
`define CMD_WR_WIPER 6'h00
`define CMD_WR_NV 6'h04
`define CMD_COPY_W2NV 6'h08
`define CMD_COPY_NV2W 6'h0c
`define CMD_RD_WIPER_DEF 6'h10
`define CMD_RD_NV_DEF 6'h14
`define SHORT_WORD_BITS 5'h08
`define LONG_WORD_BITS 5'h10
`define READ_START_EDGE 2
`define STANDBY_TAIL_EDGES 2
`define CLK_PERIOD_NS 25
`define NV_BUSY_MS 20
`define NV_BUSY_CYCLES ((`NV_BUSY_MS * 1000000) / `CLK_PERIOD_NS)
`define POWERUP_US 5
`define POWERUP_CYCLES ((`POWERUP_US * 1000) / `CLK_PERIOD_NS)

`endif

// >>> verilog/dual_pot_pkg.sv
// Types shared by the dual potentiometer serial command unit.
// Assumes the params header sits beside it.
`include "dual_pot_params.svh"

package dual_pot_pkg;

    typedef struct packed {
        logic [5:0] op;
        logic sel_b;
        logic sel_a;
    } cmd_byte_t;

    typedef struct packed {
        logic [`POT_WIDTH-1:0] wiper_a;
        logic [`POT_WIDTH-1:0] wiper_b;
    } wiper_pair_t;

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_SHIFT,
        ST_READ,
        ST_NV_BUSY
    } unit_state_t;

endpackage

// >>> verilog/dual_pot_serial_command_unit.sv
// Serial command unit of a dual 256-position digital potentiometer.
// Assumes select_low, shift clock, data line and mute come from pins.
// Notes on behaviour
// - Capture a bit per shift-clock rise, select low.
// - Execute and close input at select rise.
// - Only 8 or 16 bits execute anything.
// - Writes take 16 bits; copy/read take 8 or 16.
// - Data byte ignored in long copy/read.
// - Most significant bit first; command then data.
// - Low two command bits pick A, B or both.
// - Upper bits zero: load wipers from data.
// - Bit C4 alone: write non-volatile registers.
// - Bit C5 alone: copy wipers into non-volatile.
// - Bits C5, C4: load wipers from non-volatile.
// - Code zero is low end, all ones high.
// - Each wiper is eight bits, 256 taps.
// - Ready output low during non-volatile write.
// - Non-volatile write ends within 20 ms.
// - Standby when select high and engine idle, two edges after readback.
// - Wipers load from storage within 5 us.
// - Non-volatile registers start at mid-scale.
// - Readback drives data from second edge after select.
// - Mute zeroes wipers, blocks wiper commands.
// - Non-volatile write leaves wipers unchanged.
`timescale 1ns/100ps
`include "dual_pot_params.svh"

module dual_pot_serial_command_unit #(
    parameter int NV_BUSY_CYCLES = `NV_BUSY_CYCLES,
    parameter logic [5:0] RD_WIPER_OP = `CMD_RD_WIPER_DEF,
    parameter logic [5:0] RD_NV_OP = `CMD_RD_NV_DEF
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic select_low_in,
    input wire logic shift_clk_in,
    input wire logic data_line_in,
    output logic data_line_out,
    output logic data_line_oe_n_out,
    input wire logic mute_in,
    output logic ready_n_out,
    output logic standby_out,
    output logic [`POT_WIDTH-1:0] wiper_a_out,
    output logic [`POT_WIDTH-1:0] wiper_b_out
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two stages per pin; only stage two is looked at
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync1_next;
    logic [3:0] sync2_next;
    logic sclk_d_reg;
    logic csn_d_reg;
    logic sclk_s;
    logic csn_s;
    logic din_s;
    logic mute_s;
    logic sclk_rise;
    logic csn_rise;
    logic csn_fall;

    // Pin order from bit 0 up: select, shift clock, data, mute
    always_comb begin
        sync1_next = {mute_in, data_line_in, shift_clk_in, select_low_in};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            // Mute rests low on its pull-down; the others start high, so no rise is seen
            sync1_reg <= 4'h7;
            sync2_reg <= 4'h7;
            sclk_d_reg <= 1'b1;
            csn_d_reg <= 1'b1;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sclk_d_reg <= sync2_reg[1];
            csn_d_reg <= sync2_reg[0];
        end
    end

    // Edge finders on the settled copies
    assign csn_s = sync2_reg[0];
    assign sclk_s = sync2_reg[1];
    assign din_s = sync2_reg[2];
    assign mute_s = sync2_reg[3];
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign csn_rise = csn_s & ~csn_d_reg;
    assign csn_fall = ~csn_s & csn_d_reg;

    // ****************************************
    // Command engine
    // ****************************************
    dual_pot_pkg::unit_state_t state_reg, state_next;
    logic [15:0] shift_reg, shift_next;
    logic [4:0] count_reg, count_next;
    dual_pot_pkg::wiper_pair_t wiper_reg, wiper_next;
    dual_pot_pkg::wiper_pair_t nv_reg, nv_next;
    dual_pot_pkg::wiper_pair_t nv_pend_reg, nv_pend_next;
    logic [24:0] timer_reg, timer_next;
    logic [7:0] rd_reg, rd_next;
    logic [3:0] rd_cnt_reg, rd_cnt_next;
    logic dout_reg, dout_next;
    logic oe_n_reg, oe_n_next;
    logic rd_hit;
    logic rd_data_edge;
    logic rd_last_edge;
    dual_pot_pkg::cmd_byte_t cmd;
    logic [7:0] data_byte;
    logic len_ok;
    logic long_word;

    // ****************************************
    // Frame decode
    // ****************************************
    // The command byte sits at the top for 16 bits, at the bottom for 8;
    // in the long copy and read forms the data byte is simply never read
    always_comb begin
        long_word = (count_reg == `LONG_WORD_BITS);
        len_ok = long_word || (count_reg == `SHORT_WORD_BITS);
        cmd = long_word ? shift_reg[15:8] : shift_reg[7:0];
        data_byte = shift_reg[7:0];
        // Readback opcodes live outside the fixed case items
        rd_hit = (cmd.op == RD_WIPER_OP) || (cmd.op == RD_NV_OP);
        // Rises after select rise: one gap, eight data, then the standby tail
        rd_data_edge = (rd_cnt_reg >= 4'(`READ_START_EDGE - 1)) && (rd_cnt_reg <= 4'h8);
        rd_last_edge = (rd_cnt_reg == 4'(8 + `STANDBY_TAIL_EDGES));
    end

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        count_next = count_reg;
        wiper_next = wiper_reg;
        nv_next = nv_reg;
        nv_pend_next = nv_pend_reg;
        timer_next = timer_reg;
        rd_next = rd_reg;
        rd_cnt_next = rd_cnt_reg;
        dout_next = dout_reg;
        oe_n_next = oe_n_reg;
        unique case (state_reg)
            dual_pot_pkg::ST_POWERUP: begin
                // Recall stored positions well inside the power-up budget
                wiper_next = nv_reg;
                timer_next = timer_reg + 25'h0000001;
                if (timer_reg >= 25'(`POWERUP_CYCLES - 1)) begin
                    state_next = dual_pot_pkg::ST_IDLE;
                    timer_next = 25'h0000000;
                end
            end
            dual_pot_pkg::ST_IDLE: begin
                // Clearing the shift register keeps old bits out of a short frame
                if (csn_fall) begin
                    state_next = dual_pot_pkg::ST_SHIFT;
                    count_next = 5'h00;
                    shift_next = 16'h0000;
                end
            end
            dual_pot_pkg::ST_SHIFT: begin
                // Count saturates, so an over-long frame can never wrap to 8 or 16
                if (sclk_rise && !csn_s && count_reg != 5'h1f) begin
                    shift_next = {shift_reg[14:0], din_s};
                    count_next = count_reg + 5'h01;
                end
                if (csn_rise) begin
                    state_next = dual_pot_pkg::ST_IDLE;
                    if (len_ok && (cmd.sel_a || cmd.sel_b)) begin
                        unique case (cmd.op)
                            `CMD_WR_WIPER: begin
                                if (long_word && !mute_s) begin
                                    if (cmd.sel_a) wiper_next.wiper_a = data_byte;
                                    if (cmd.sel_b) wiper_next.wiper_b = data_byte;
                                end
                            end
                            `CMD_WR_NV: begin
                                if (long_word) begin
                                    nv_pend_next = nv_reg;
                                    if (cmd.sel_a) nv_pend_next.wiper_a = data_byte;
                                    if (cmd.sel_b) nv_pend_next.wiper_b = data_byte;
                                    state_next = dual_pot_pkg::ST_NV_BUSY;
                                    timer_next = 25'h0000000;
                                end
                            end
                            `CMD_COPY_W2NV: begin
                                nv_pend_next = nv_reg;
                                if (cmd.sel_a) nv_pend_next.wiper_a = wiper_reg.wiper_a;
                                if (cmd.sel_b) nv_pend_next.wiper_b = wiper_reg.wiper_b;
                                state_next = dual_pot_pkg::ST_NV_BUSY;
                                timer_next = 25'h0000000;
                            end
                            `CMD_COPY_NV2W: begin
                                if (!mute_s) begin
                                    if (cmd.sel_a) wiper_next.wiper_a = nv_reg.wiper_a;
                                    if (cmd.sel_b) wiper_next.wiper_b = nv_reg.wiper_b;
                                end
                            end
                            default: begin
                                // Readback picks A unless only B is selected
                                if (rd_hit) begin
                                    if (cmd.op == RD_WIPER_OP) begin
                                        rd_next = cmd.sel_a ? wiper_reg.wiper_a : wiper_reg.wiper_b;
                                    end else begin
                                        rd_next = cmd.sel_a ? nv_reg.wiper_a : nv_reg.wiper_b;
                                    end
                                    rd_cnt_next = 4'h0;
                                    oe_n_next = 1'b0;
                                    state_next = dual_pot_pkg::ST_READ;
                                end
                                // Any other byte leaves every register as it was
                            end
                        endcase
                    end
                end
            end
            dual_pot_pkg::ST_READ: begin
                // Edge 1 is a gap, edges 2..9 carry data MSB first, two more close
                if (sclk_rise && csn_s) begin
                    rd_cnt_next = rd_cnt_reg + 4'h1;
                    if (rd_data_edge) begin
                        dout_next = rd_reg[7];
                        rd_next = {rd_reg[6:0], 1'b0};
                    end
                    if (rd_last_edge) begin
                        oe_n_next = 1'b1;
                        dout_next = 1'b0;
                        state_next = dual_pot_pkg::ST_IDLE;
                    end
                end
                // Next select fall hands the line back to the host
                if (csn_fall) begin
                    oe_n_next = 1'b1;
                    dout_next = 1'b0;
                    state_next = dual_pot_pkg::ST_SHIFT;
                    count_next = 5'h00;
                    shift_next = 16'h0000;
                end
            end
            dual_pot_pkg::ST_NV_BUSY: begin
                // Storage settles at the end so a power loss cannot half-write it
                // Select activity here is not heard; the host must watch ready first
                timer_next = timer_reg + 25'h0000001;
                if (timer_reg >= 25'(NV_BUSY_CYCLES - 1)) begin
                    nv_next = nv_pend_reg;
                    state_next = dual_pot_pkg::ST_IDLE;
                    timer_next = 25'h0000000;
                end
            end
        endcase
        if (mute_s) begin
            wiper_next = '0;
        end
    end

    // Reset is the power-on trigger, so it restarts the recall from storage
    // Limitation: storage sits in flops, so reset also returns it to mid-scale
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= dual_pot_pkg::ST_POWERUP;
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
            wiper_reg <= '0;
            nv_reg <= {`POT_MID_SCALE, `POT_MID_SCALE};
            nv_pend_reg <= {`POT_MID_SCALE, `POT_MID_SCALE};
            timer_reg <= 25'h0000000;
            rd_reg <= 8'h00;
            rd_cnt_reg <= 4'h0;
            dout_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            count_reg <= count_next;
            wiper_reg <= wiper_next;
            nv_reg <= nv_next;
            nv_pend_reg <= nv_pend_next;
            timer_reg <= timer_next;
            rd_reg <= rd_next;
            rd_cnt_reg <= rd_cnt_next;
            dout_reg <= dout_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Wiper codes map straight onto tap order, zero at the low end
    assign wiper_a_out = wiper_reg.wiper_a;
    assign wiper_b_out = wiper_reg.wiper_b;
    assign ready_n_out = (state_reg != dual_pot_pkg::ST_NV_BUSY);
    // Standby waits for the engine to idle, so a readback tail holds it off
    assign standby_out = csn_s && (state_reg == dual_pot_pkg::ST_IDLE);
    assign data_line_out = dout_reg;
    assign data_line_oe_n_out = oe_n_reg;

endmodule

// >>> verification/dual_pot_checker.sv
// Port checks for the serial command unit.
// Assumes it is bound into the unit, which passes on its busy length.
`timescale 1ns/100ps
module dual_pot_checker #(
    parameter int NV_BUSY_CYCLES = 50
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic select_low_in,
    input wire logic shift_clk_in,
    input wire logic data_line_in,
    input wire logic data_line_out,
    input wire logic data_line_oe_n_out,
    input wire logic mute_in,
    input wire logic ready_n_out,
    input wire logic standby_out,
    input wire logic [7:0] wiper_a_out,
    input wire logic [7:0] wiper_b_out
);
    logic [31:0] busy_reg, busy_next;
    logic [7:0] up_reg, up_next;
    // Busy length, and age since reset saturating so it never wraps
    always_comb begin
        busy_next = ready_n_out ? 32'h0 : busy_reg + 32'h1;
        up_next = (up_reg == 8'hff) ? up_reg : up_reg + 8'h01;
    end
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            busy_reg <= 32'h0;
            up_reg <= 8'h00;
        end else begin
            busy_reg <= busy_next;
            up_reg <= up_next;
        end
    end
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    a_busy_bound: assert property (busy_reg <= NV_BUSY_CYCLES)
        else $error("ready low too long");
    a_busy_exact: assert property ($rose(ready_n_out) |-> busy_reg == NV_BUSY_CYCLES)
        else $error("busy length wrong");
    a_oe_sel_low: assert property ((!select_low_in)[*5] |-> data_line_oe_n_out)
        else $error("line driven during frame");
    a_oe_after_rise: assert property ($fell(data_line_oe_n_out) |->
        select_low_in && $past(select_low_in, 2))
        else $error("line driven too early");
    a_stby_busy: assert property ((!select_low_in)[*5] |-> !standby_out)
        else $error("standby while selected");
    a_stby_idle: assert property ((up_reg == 8'hff && select_low_in && ready_n_out
        && data_line_oe_n_out)[*8] |-> standby_out)
        else $error("no standby when idle");
    a_mute_zero: assert property (mute_in[*5] |-> {wiper_a_out, wiper_b_out} == 16'h0000)
        else $error("mute left wipers set");
    a_sel_only: assert property ((!select_low_in && !mute_in)[*6]
        |=> $stable({wiper_a_out, wiper_b_out}))
        else $error("wiper moved mid frame");
    a_nv_keep: assert property ((!ready_n_out && !mute_in)[*5]
        |=> $stable({wiper_a_out, wiper_b_out}))
        else $error("wiper moved while busy");
    c_nv_write: cover property ($rose(ready_n_out));
    c_readback: cover property ($fell(data_line_oe_n_out));
    c_mute: cover property (mute_in && wiper_b_out == 8'h00);
endmodule

bind dual_pot_serial_command_unit dual_pot_checker #(.NV_BUSY_CYCLES(NV_BUSY_CYCLES)) chk_i (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .select_low_in(select_low_in),
    .shift_clk_in(shift_clk_in), .data_line_in(data_line_in), .data_line_out(data_line_out),
    .data_line_oe_n_out(data_line_oe_n_out), .mute_in(mute_in), .ready_n_out(ready_n_out),
    .standby_out(standby_out), .wiper_a_out(wiper_a_out), .wiper_b_out(wiper_b_out));

// >>> verification/pot_host_model.sv
// Host end of the three-wire link: select, shift clock and data.
// Assumes the bench resolves the shared data line from the unit's enable.
`timescale 1ns/100ps
module pot_host_model (
    input wire logic clk_in,
    input wire logic line_in,
    output logic select_low_out,
    output logic shift_clk_out,
    output logic data_out
);
    initial begin
        select_low_out = 1'b1;
        shift_clk_out = 1'b0;
        data_out = 1'b0;
    end
    // Half of a 200 ns shift period, moved on falling core edges
    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask
    // Frame of n bits from the top of w; clock stands still outside it
    task automatic frame(input logic [15:0] w, input int n);
        @(negedge clk_in);
        select_low_out <= 1'b0;
        half();
        for (int i = 15; i > 15 - n; i--) begin
            data_out <= w[i];
            half();
            shift_clk_out <= 1'b1;
            half();
            shift_clk_out <= 1'b0;
        end
        half();
        select_low_out <= 1'b1;
        repeat (3) half();
    endtask
    // Select stays high; rise one is a gap, rises two to nine carry the byte,
    // rises ten and eleven are the tail after which the unit idles
    task automatic read(output logic [7:0] v);
        for (int k = 1; k <= 11; k++) begin
            shift_clk_out <= 1'b1;
            data_out <= ~data_out; // Released line: no stale level
            half();
            shift_clk_out <= 1'b0;
            half();
            if (k >= 2 && k <= 9)
                v = {v[6:0], line_in};
        end
        repeat (2) half();
    endtask
endmodule

// >>> verification/tb_dual_pot_serial_command_unit.sv
// Bench for the serial command unit: a table of frames, then hand tests.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/100ps
module tb_dual_pot_serial_command_unit;
    localparam int BUSY = 50;
    typedef struct {logic [15:0] w; int n; logic m; logic [15:0] e;} row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mute = 1'b0;
    logic oe_n, dout, sel_n, sclk, hdat, rdy_n, stby;
    logic [7:0] wa, wb, rv;
    wire line = oe_n ? hdat : dout;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int k;
    // Frame word, bit count, mute, expected wipers A then B
    row_t rows[17] = '{
        '{16'h015a, 16, 1'b0, 16'h5a80},
        '{16'h02c3, 16, 1'b0, 16'h5ac3},
        '{16'h0300, 16, 1'b0, 16'h0000},
        '{16'h03ff, 16, 1'b0, 16'hffff},
        '{16'h0177, 8, 1'b0, 16'hffff},
        '{16'h0310, 9, 1'b0, 16'hffff},
        '{16'h0310, 15, 1'b0, 16'hffff},
        '{16'h1112, 16, 1'b0, 16'hffff},
        '{16'h3300, 8, 1'b0, 16'h1280},
        '{16'h0244, 16, 1'b0, 16'h1244},
        '{16'h22ff, 16, 1'b0, 16'h1244},
        '{16'h0300, 16, 1'b0, 16'h0000},
        '{16'h33a5, 16, 1'b0, 16'h1244},
        '{16'hc355, 16, 1'b0, 16'h1244},
        '{16'h0099, 16, 1'b0, 16'h1244},
        '{16'h0377, 16, 1'b1, 16'h0000},
        '{16'h3300, 8, 1'b0, 16'h1244}
    };
    dual_pot_serial_command_unit #(.NV_BUSY_CYCLES(BUSY)) dual_pot_serial_command_unit_i (
        .core_clk_in(clk), .reset_in(rst), .select_low_in(sel_n), .shift_clk_in(sclk),
        .data_line_in(line), .data_line_out(dout), .data_line_oe_n_out(oe_n), .mute_in(mute),
        .ready_n_out(rdy_n), .standby_out(stby), .wiper_a_out(wa), .wiper_b_out(wb));
    pot_host_model pot_host_model_i (.clk_in(clk), .line_in(line), .select_low_out(sel_n),
        .shift_clk_out(sclk), .data_out(hdat));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk({15'h0000, g}, {15'h0000, e});
    endtask
    // Bounded wait, since a frame during busy would be lost
    task automatic wait_ready(output int n);
        for (n = 0; n < 100 && rdy_n !== 1'b1; n++) @(negedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cycle ceiling well above the expected run of some 3500 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        chk({wa, wb}, 16'h0000);
        chk1(oe_n, 1'b1);
        rst <= 1'b0;
        repeat (203) @(negedge clk);
        chk({wa, wb}, 16'h8080);
        foreach (rows[i]) begin
            mute <= rows[i].m;
            pot_host_model_i.frame(rows[i].w, rows[i].n);
            wait_ready(k);
            chk({wa, wb}, rows[i].e);
        end
        pot_host_model_i.frame(16'h1377, 16);
        chk1(rdy_n, 1'b0);
        wait_ready(k);
        chk1(k <= BUSY, 1'b1);
        chk({wa, wb}, 16'h1244);
        pot_host_model_i.frame(16'h4100, 8);
        pot_host_model_i.read(rv);
        chk({8'h00, rv}, 16'h0012);
        chk1(stby, 1'b1);
        pot_host_model_i.frame(16'h52ff, 16);
        pot_host_model_i.read(rv);
        chk({8'h00, rv}, 16'h0077);
        // Reset in mid-run: wipers drop, line released, link works again
        rst <= 1'b1;
        repeat (3) @(negedge clk);
        chk({wa, wb}, 16'h0000);
        chk1(oe_n, 1'b1);
        rst <= 1'b0;
        repeat (203) @(negedge clk);
        pot_host_model_i.frame(16'h015a, 16);
        wait_ready(k);
        chk({8'h00, wa}, 16'h005a);
        test_done();
    end
endmodule
